// ===== hdl/occd_class_rom.sv
// code to class flag table
`timescale 1ns/100ps
module occd_class_rom (
    input wire logic [7:0] op_code,
    output occd_pkg::occd_class_s flags
);
    logic [3:0] hi;
    logic [3:0] lo;
    always_comb begin
        hi = op_code[7:4];
        lo = op_code[3:0];
        flags = '0;
        // arithmetic group
        if ((hi == 4'h0 && lo >= 4'h1 && lo <= 4'h6) || (op_code == 8'h11) || (op_code == 8'h12)
            || (hi == 4'h1 && lo >= 4'h4 && lo <= 4'h6) || (hi == 4'h2 && lo <= 4'h7)
            || (hi == 4'h3 && lo <= 4'h2) || (hi == 4'h3 && lo >= 4'h4 && lo <= 4'h7)) begin
            flags.need_a = 1'b1;
            flags.need_m = 1'b1;
            flags.a_chain = 1'b1;
            flags.r_chain = 1'b1;
            flags.m_chain_if_fast = 1'b1;
        end else if (hi == 4'h6 && lo <= 4'h4) begin
            flags.need_a = 1'b1;
            flags.need_m = 1'b1;
            flags.a_chain = 1'b1;
            flags.r_chain = 1'b1;
            flags.m_chain_if_fast = 1'b1;
        end else if (op_code == 8'h65 || op_code == 8'h66) begin
            flags.need_a = 1'b1;
            flags.need_m = 1'b1;
            flags.a_chain = 1'b1;
            flags.m_chain = 1'b1;
            flags.r_chain = 1'b1;
        end else if (op_code == 8'h43 || op_code == 8'h48) begin
            flags.need_m = 1'b1;
            flags.r_chain = 1'b1;
            flags.m_chain_if_fast = 1'b1;
        end else if (hi == 4'h5 && lo <= 4'h3) begin
            flags.need_a = 1'b1;
            flags.m_chain = 1'b1;
            flags.r_chain = 1'b1;
            flags.shift_xfer = 1'b1;
            flags.direct_sel_load = 1'b1;
        end else if (hi == 4'h5 && lo >= 4'h5 && lo <= 4'h9) begin
            flags.need_a = 1'b1;
            flags.a_chain = 1'b1;
            flags.m_chain = 1'b1;
            flags.r_chain = 1'b1;
            flags.shift_xfer = 1'b1;
            flags.direct_sel_load = 1'b1;
        end else if (hi == 4'h4 && ((lo <= 4'h2) || (lo >= 4'h5 && lo <= 4'h7))) begin
            flags.need_a = 1'b1;
            flags.m_chain = 1'b1;
            flags.r_chain_if_fast = 1'b1;
            flags.conflict_check = 1'b1;
            flags.direct_sel_load = 1'b1;
        end else if (op_code == occd_pkg::CODE_STORE_LAST_JUMP) begin
            flags.last_jump_to_m = 1'b1;
            flags.r_chain_if_fast = 1'b1;
        end else if (op_code == occd_pkg::CODE_UNCOND_XFER) begin
            flags.need_a = 1'b1;
            flags.a_chain = 1'b1;
            flags.r_chain = 1'b1;
            flags.prog_ctr_to_m = 1'b1;
        end else if (op_code == 8'h70 || op_code == 8'h71 || op_code == 8'h75 || op_code == 8'h76) begin
            flags.need_a = 1'b1;
            flags.m_chain = 1'b1;
            flags.a_chain = 1'b1;
            flags.direct_sel_load = 1'b1;
        end else if (hi == 4'h7 && lo >= 4'h2 && lo <= 4'h4) begin
            flags.need_a = 1'b1;
            flags.m_chain = 1'b1;
            flags.direct_sel_load = 1'b1;
        end else if ((hi == 4'h8 && lo <= 4'h3) || op_code == 8'h85 || op_code == 8'h86) begin
            flags.need_a = 1'b1;
            flags.a_chain = 1'b1;
            flags.r_chain = 1'b1;
            flags.no_m_to_ctr_option = (op_code == 8'h85 || op_code == 8'h86);
        end else if (op_code == 8'h09 || op_code == 8'h19) begin
            flags.need_m = 1'b1;
            flags.r_chain = 1'b1;
            flags.display_in = 1'b1;
        end else if (op_code == 8'h29 || op_code == 8'h39) begin
            flags.need_a = 1'b1;
            flags.m_chain = 1'b1;
            flags.display_out = 1'b1;
            flags.conflict_check = 1'b1;
            flags.direct_sel_load = 1'b1;
        end
        // 00, 90, 91, 95-97, 99 and unassigned codes keep all flags low
    end
endmodule

// ===== hdl/occd_decoder.sv
// operation code control class decoder top
// Overview of operation
// - arithmetic codes need A and M, A-input and result chains; M chain if fast.
// - extract 60-64 like arithmetic; fetch 43,48 need M and result chain; M chain if fast.
// - extract 65,66 need both operands and all three chains.
// - single shift 50-53 need A, M-input and result chains only.
// - all shift codes send two low M digits to the arithmetic unit.
// - double shift 55-59 need A, all three chains.
// - store codes need A, M-input chain; result chain only if M fast.
// - shift, store, compare, display-out load selector from A field directly.
// - store-last-jump routes last jump counter to M; result if M fast.
// - unconditional transfer needs A, A-input and result chains.
// - unconditional transfer routes program counter to M through the B-adder.
// - comparisons need A, no result; 70,71,75,76 also use A-input chain.
// - index codes need A, A-input and result chains.
// - index codes 85,86 lack the store-counter-to-M option.
// - display-in codes need M and result chain via display address.
// - display-out codes need A, M-input chain, display address, conflict check.
// - halt, skip, plain transfers raise no flag at all.
// - unconditional transfer uses A-input chain, not M-input chain.
// - direct selector load pulses at timing phase zero.
// - shift digit transfer pulses at timing phase five.
// - general clear empties instruction registers so a null code decodes.
`timescale 1ns/100ps
module occd_decoder (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic general_clear_signal,
    input wire logic load_second_instruction_register,
    input occd_pkg::occd_instr_s first_instruction_register,
    input wire logic timing_phase_zero,
    input wire logic timing_phase_five,
    output occd_pkg::occd_class_s class_flags,
    output logic direct_selector_load_pulse,
    output logic [19:0] selector_load_value,
    output logic shift_digit_transfer_pulse,
    output logic [7:0] shift_digits,
    output logic [19:0] display_address,
    output logic [7:0] current_op_code
);
    typedef struct packed {
        occd_pkg::occd_class_s flags;
        logic sel_pulse;
        logic [19:0] sel_val;
        logic shf_pulse;
        logic [7:0] shf_dig;
        logic [19:0] disp_addr;
        logic [7:0] op;
    } occd_state_s;

    occd_pkg::occd_instr_s second_instruction_register;
    occd_pkg::occd_class_s raw_flags;
    occd_pkg::occd_class_s eff_flags;
    occd_state_s st_r;
    occd_state_s st_nxt;

    occd_ir_hold u_hold (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .general_clear_signal(general_clear_signal),
        .load(load_second_instruction_register),
        .instr_in(first_instruction_register),
        .instr_q(second_instruction_register)
    );

    occd_class_rom u_rom (
        .op_code(second_instruction_register.op_code),
        .flags(raw_flags)
    );

    always_comb begin
        eff_flags = raw_flags;
        // conditional chains resolved from whether M names a fast register
        if (raw_flags.m_chain_if_fast && second_instruction_register.m_is_fast) begin
            eff_flags.m_chain = 1'b1;
        end
        if (raw_flags.r_chain_if_fast && second_instruction_register.m_is_fast) begin
            eff_flags.r_chain = 1'b1;
        end
        st_nxt = st_r;
        st_nxt.flags = eff_flags;
        st_nxt.op = second_instruction_register.op_code;
        st_nxt.sel_pulse = raw_flags.direct_sel_load && timing_phase_zero;
        st_nxt.sel_val = second_instruction_register.a_field;
        st_nxt.shf_pulse = raw_flags.shift_xfer && timing_phase_five;
        st_nxt.shf_dig = second_instruction_register.m_field[7:0];
        // display codes go through the fixed memory cell
        st_nxt.disp_addr = (raw_flags.display_in || raw_flags.display_out) ? occd_pkg::DISPLAY_ADDR
            : occd_pkg::A_FIELD_RST;
        if (general_clear_signal) begin
            st_nxt = '0;
        end
    end

    // registered outputs cost one cycle of latency but keep glitches off the chain lines
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign class_flags = st_r.flags;
    assign direct_selector_load_pulse = st_r.sel_pulse;
    assign selector_load_value = st_r.sel_val;
    assign shift_digit_transfer_pulse = st_r.shf_pulse;
    assign shift_digits = st_r.shf_dig;
    assign display_address = st_r.disp_addr;
    assign current_op_code = st_r.op;
endmodule

// ===== hdl/occd_ir_hold.sv
// second instruction register holder with general clear
`timescale 1ns/100ps
module occd_ir_hold (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic general_clear_signal,
    input wire logic load,
    input occd_pkg::occd_instr_s instr_in,
    output occd_pkg::occd_instr_s instr_q
);
    typedef struct packed {
        occd_pkg::occd_instr_s ir;
    } occd_hold_s;
    occd_hold_s st_r;
    occd_hold_s st_nxt;
    always_comb begin
        st_nxt = st_r;
        if (general_clear_signal) begin
            st_nxt.ir = '0;
        end else if (load) begin
            st_nxt.ir = instr_in;
        end
    end
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign instr_q = st_r.ir;
endmodule

// ===== hdl/occd_pkg.sv
// package for the operation code class decoder
package occd_pkg;
    localparam int DIGIT_W = 4;
    localparam int CODE_W = 8;
    localparam logic [7:0] CODE_NULL = 8'h00;
    localparam logic [7:0] CODE_STORE_LAST_JUMP = 8'h93;
    localparam logic [7:0] CODE_UNCOND_XFER = 8'h92;
    localparam logic [7:0] CODE_DISPLAY_ADDR_HI = 8'h02;
    localparam logic [7:0] CODE_DISPLAY_ADDR_LO = 8'h65;
    localparam logic [19:0] DISPLAY_ADDR = 20'h02650;
    localparam int MEM_FIELD_W = 20;
    localparam int A_FIELD_W = 20;
    localparam logic [7:0] SHIFT_DIGITS_RST = 8'h00;
    localparam logic [19:0] A_FIELD_RST = 20'h00000;

    typedef struct packed {
        logic need_a;
        logic need_m;
        logic a_chain;
        logic m_chain;
        logic r_chain;
        logic m_chain_if_fast;
        logic r_chain_if_fast;
        logic direct_sel_load;
        logic shift_xfer;
        logic last_jump_to_m;
        logic prog_ctr_to_m;
        logic no_m_to_ctr_option;
        logic display_in;
        logic display_out;
        logic conflict_check;
    } occd_class_s;

    typedef struct packed {
        logic [7:0] op_code;
        logic [19:0] a_field;
        logic [19:0] m_field;
        logic m_is_fast;
    } occd_instr_s;
endpackage

// ===== testbench/occd_chain_model.sv
// far-side chain control model: holds selector and shift control loads
`timescale 1ns/100ps
module occd_chain_model (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic sel_pulse,
    input wire logic [19:0] sel_value,
    input wire logic shift_pulse,
    input wire logic [7:0] digits,
    output logic [19:0] selector_r,
    output logic [7:0] shift_ctl_r
);
    // only a pulse may change what the chains see, so a stray pulse shows up here
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            selector_r <= 20'h00000;
            shift_ctl_r <= 8'h00;
        end else begin
            if (sel_pulse) selector_r <= sel_value;
            if (shift_pulse) shift_ctl_r <= digits;
        end
    end
endmodule

// ===== testbench/occd_decoder_asserts.sv
// concurrent checks on the class decoder ports
`timescale 1ns/100ps
module occd_decoder_asserts (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic general_clear_signal,
    input wire logic load_second_instruction_register,
    input occd_pkg::occd_instr_s first_instruction_register,
    input wire logic timing_phase_zero,
    input wire logic timing_phase_five,
    input occd_pkg::occd_class_s class_flags,
    input wire logic direct_selector_load_pulse,
    input wire logic [19:0] selector_load_value,
    input wire logic shift_digit_transfer_pulse,
    input wire logic [7:0] shift_digits,
    input wire logic [19:0] display_address,
    input wire logic [7:0] current_op_code
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence s_load;
        load_second_instruction_register && !general_clear_signal ##1 !general_clear_signal;
    endsequence
    sequence s_quiet;
        (!load_second_instruction_register && !general_clear_signal) [*2];
    endsequence
    // pulse and flags leave the same register stage, so the flags of this cycle go with last cycle's phase
    a_sel_pulse_cause: assert property (direct_selector_load_pulse ==
        ($past(timing_phase_zero && !general_clear_signal && !sys_rst) && class_flags.direct_sel_load))
        else $error("selector load pulse wrong");
    a_shift_pulse_cause: assert property (shift_digit_transfer_pulse ==
        ($past(timing_phase_five && !general_clear_signal && !sys_rst) && class_flags.shift_xfer))
        else $error("shift digit pulse wrong");
    a_load_op_code: assert property (s_load |=> current_op_code == $past(first_instruction_register.op_code, 2))
        else $error("held code not loaded");
    a_field_copy: assert property (s_load |=> selector_load_value == $past(first_instruction_register.a_field, 2))
        else $error("selector value not loaded");
    a_clear_empties: assert property (general_clear_signal |=> ##1 (class_flags == '0 && current_op_code == 8'h00))
        else $error("clear left state");
    a_hold_stable: assert property (s_quiet |=> $stable(class_flags) && $stable(current_op_code))
        else $error("flags moved without load");
    a_shift_class: assert property (class_flags.shift_xfer |-> class_flags.need_a && !class_flags.need_m
        && class_flags.m_chain && class_flags.r_chain && class_flags.direct_sel_load) else $error("shift class wrong");
    a_xfer_chains: assert property (class_flags.prog_ctr_to_m |-> class_flags.need_a && class_flags.a_chain
        && !class_flags.m_chain && class_flags.r_chain) else $error("transfer chains wrong");
    a_jump_no_operand: assert property (class_flags.last_jump_to_m |-> !(class_flags.need_a || class_flags.need_m
        || class_flags.a_chain || class_flags.m_chain)) else $error("last jump requests operand");
    a_display_addr: assert property (display_address ==
        ((class_flags.display_in || class_flags.display_out) ? occd_pkg::DISPLAY_ADDR : 20'h00000))
        else $error("display address wrong");
endmodule
bind occd_decoder occd_decoder_asserts u_chk (.mclk, .sys_rst, .general_clear_signal,
    .load_second_instruction_register, .first_instruction_register, .timing_phase_zero, .timing_phase_five,
    .class_flags, .direct_selector_load_pulse, .selector_load_value, .shift_digit_transfer_pulse,
    .shift_digits, .display_address, .current_op_code);

// ===== testbench/occd_decoder_bench.sv
// self-checking bench for the class decoder
`timescale 1ns/100ps
module occd_decoder_bench;
    logic mclk, sys_rst, gcs, ld, ph0, ph5, sel_p, sh_p;
    occd_pkg::occd_instr_s instr;
    occd_pkg::occd_class_s flg;
    logic [19:0] sel_v, disp, sel_r;
    logic [7:0] dig, code, shf_r;
    int miscompares = 0, checks = 0, cyc = 0;
    wire logic [11:0] got = {flg.need_a, flg.need_m, flg.a_chain, flg.m_chain, flg.r_chain, flg.direct_sel_load,
        flg.shift_xfer, flg.last_jump_to_m, flg.prog_ctr_to_m, flg.display_in, flg.display_out, flg.no_m_to_ctr_option};
    always #12.5 mclk = ~mclk;
    occd_decoder u_dut (.mclk(mclk), .sys_rst(sys_rst), .general_clear_signal(gcs), .load_second_instruction_register(ld),
        .first_instruction_register(instr), .timing_phase_zero(ph0), .timing_phase_five(ph5), .class_flags(flg),
        .direct_selector_load_pulse(sel_p), .selector_load_value(sel_v), .shift_digit_transfer_pulse(sh_p),
        .shift_digits(dig), .display_address(disp), .current_op_code(code));
    occd_chain_model u_far (.mclk(mclk), .sys_rst(sys_rst), .sel_pulse(sel_p), .sel_value(sel_v),
        .shift_pulse(sh_p), .digits(dig), .selector_r(sel_r), .shift_ctl_r(shf_r));
    task automatic check(input logic [19:0] seen, input logic [19:0] want);
        checks++;
        if (seen !== want) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    // order: need_a need_m a m r sel shift lastjump progctr disp_in disp_out
    function automatic logic [10:0] exp_flags(input logic [7:0] c, input logic f);
        case (c) inside
            [8'h01:8'h06], 8'h11, 8'h12, [8'h14:8'h16], [8'h20:8'h27], [8'h30:8'h32], [8'h34:8'h37],
            [8'h60:8'h64]: return {3'b111, f, 7'b1000000};
            8'h65, 8'h66: return 11'b11111000000;
            [8'h50:8'h53]: return 11'b10011110000;
            [8'h55:8'h59]: return 11'b10111110000;
            8'h43, 8'h48: return {3'b010, f, 7'b1000000};
            [8'h40:8'h42], [8'h45:8'h47]: return {4'b1001, f, 6'b100000};
            8'h93: return {4'b0000, f, 6'b001000};
            8'h92: return 11'b10101000100;
            8'h70, 8'h71, 8'h75, 8'h76: return 11'b10110100000;
            [8'h72:8'h74]: return 11'b10010100000;
            [8'h80:8'h83], 8'h85, 8'h86: return 11'b10101000000;
            8'h09, 8'h19: return 11'b01001000010;
            8'h29, 8'h39: return 11'b10010100001;
            default: return 11'b00000000000;
        endcase
    endfunction
    task automatic apply(input logic [7:0] c, input logic f);
        logic [10:0] e;
        e = exp_flags(c, f);
        @(posedge mclk);
        ld <= 1'b1;
        instr <= {c, c, 12'h5A3, 12'h3C9, c, f};
        @(posedge mclk);
        ld <= 1'b0;
        @(posedge mclk);
        // phases on separate cycles so a swapped phase gate cannot hide
        {ph0, ph5} <= 2'b10;
        @(posedge mclk);
        {ph0, ph5} <= 2'b01;
        #1;
        check(got, {e, c == 8'h85 || c == 8'h86});
        check({sel_p, sh_p}, {e[5], 1'b0});
        check(disp, (e[1] | e[0]) ? occd_pkg::DISPLAY_ADDR : 20'h00000);
        check({dig, code}, {c, c});
        @(posedge mclk);
        {ph0, ph5} <= 2'b00;
        #1;
        check({sel_p, sh_p}, {1'b0, e[4]});
        if (e[5]) check(sel_r, {c, 12'h5A3});
        @(posedge mclk);
        #1;
        check({sel_p, sh_p}, 2'b00);
        if (e[4]) check(shf_r, c);
    endtask
    task automatic give_verdict();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // each apply takes six cycles; the ceiling leaves ample margin over the run
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 4500) begin
            miscompares++;
            give_verdict();
        end
    end
    initial begin
        mclk = 1'b0;
        sys_rst = 1'b1;
        {gcs, ld, ph0, ph5} = 4'b0000;
        instr = '0;
        repeat (12) @(posedge mclk);
        sys_rst <= 1'b0;
        // every code, with M in memory and in a fast register, non-decimal codes too
        for (int i = 0; i < 512; i++) apply(i[8:1], i[0]);
        apply(8'h50, 1'b0);
        @(posedge mclk);
        {gcs, ld} <= 2'b11;
        instr <= {8'h92, 41'h0};
        @(posedge mclk);
        {gcs, ld} <= 2'b00;
        @(posedge mclk);
        #1;
        check({got, code}, 20'h00000);
        // let the clear assertion reach its check edge before ending
        repeat (2) @(posedge mclk);
        #1;
        check({got, code}, 20'h00000);
        check(disp, 20'h00000);
        give_verdict();
    end
endmodule
